// ==== sim/flag_branch_bit_clear_exec_tb.sv ====
// bench: branch and bit-clear executor driven one word at a time
`timescale 1ns/1ps
module flag_branch_bit_clear_exec_tb;
  import fbx_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic        instrValid = 1'b0;
  logic        carry = 1'b0;
  logic        negative = 1'b0;
  logic        extEnable = 1'b0;
  logic [3:0]  bankSelect = 4'h3;
  logic [11:0] fsrBase = 12'h100;
  logic [7:0]  memRdata = 8'h00;
  fbx_mem_t    mem;
  logic [20:0] pc;
  logic        pcLoad;
  logic        idleCycle;
  logic        cycDone;
  logic [1:0]  qPhase;
  int          mismatches = 0;
  int          check_count = 0;
  int          nLoad, nIdle, nRe, nWe, nDone;
  logic [20:0] loadPc;
  logic [11:0] reAddr, weAddr;
  logic [7:0]  weData;

  always #4 clk = ~clk;

  fbx_exec u_fbx_exec (.instr(instr), .instrValid(instrValid),
    .carry(carry), .negative(negative), .extEnable(extEnable),
    .bankSelect(bankSelect), .fsrBase(fsrBase), .memRdata(memRdata),
    .clk(clk), .nrst(nrst), .mem(mem), .pc(pc), .pcLoad(pcLoad),
    .idleCycle(idleCycle), .cycDone(cycDone), .qPhase(qPhase));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(string what, logic [20:0] exp, logic [20:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // fresh reset per word so the first fetch sits at address zero
  task automatic run_word(logic [15:0] word);
    int i;
    @(negedge clk);
    nrst = 1'b0;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    i = 0;
    while (qPhase !== 2'h2 && i < 8) begin
      @(negedge clk);
      i++;
    end
    if (i == 8) begin
      mismatches++;
      $display("[FAIL] phase wait expected 2 seen %h", qPhase);
      wrap_up();
    end
    instr = word;
    instrValid = 1'b1;
    {nLoad, nIdle, nRe, nWe, nDone} = '0;
    repeat (12) begin
      @(negedge clk);
      instrValid = 1'b0;
      if (pcLoad === 1'b1) begin
        nLoad++;
        loadPc = pc;
      end
      if (idleCycle === 1'b1) nIdle++;
      if (cycDone === 1'b1) nDone++;
      if (mem.re === 1'b1) begin
        nRe++;
        reAddr = mem.addr;
      end
      if (mem.we === 1'b1) begin
        nWe++;
        {weAddr, weData} = {mem.addr, mem.data};
      end
    end
    chk("cycle ends", 21'h3, 21'(nDone));
  endtask : run_word

  task automatic test_branch(logic [7:0] op, logic c, logic ng,
                             logic [7:0] n, logic tk);
    logic [20:0] target;
    target = 21'h000002 + {{12{n[7]}}, n, 1'b0};
    carry = c;
    negative = ng;
    run_word({op, n});
    chk("branch count", {20'h0, tk}, 21'(nLoad));
    if (tk) chk("branch target", target, loadPc);
    chk("idle cycles", tk ? 21'h4 : 21'h0, 21'(nIdle));
    chk("branch writes", 21'h0, 21'(nWe));
    chk("final pc", tk ? target + 21'h2 : 21'h8, pc);
  endtask : test_branch

  task automatic test_bitclr(logic [2:0] b, logic a, logic [7:0] f,
                             logic ext, logic [7:0] rd, logic [11:0] ea);
    extEnable = ext;
    memRdata = rd;
    run_word({4'h9, b, a, f});
    chk("read count", 21'h1, 21'(nRe));
    chk("read addr", {9'h0, ea}, {9'h0, reAddr});
    chk("write count", 21'h1, 21'(nWe));
    chk("write addr", {9'h0, ea}, {9'h0, weAddr});
    chk("write data", {13'h0, rd & ~(8'h01 << b)}, {13'h0, weData});
    chk("clear jumps", 21'h0, 21'(nLoad));
  endtask : test_bitclr

  initial begin
    test_branch(8'he2, 1'b1, 1'b0, 8'h05, 1'b1);
    test_branch(8'he2, 1'b0, 1'b1, 8'h05, 1'b0);
    test_branch(8'he2, 1'b1, 1'b0, 8'h7f, 1'b1);
    test_branch(8'he6, 1'b0, 1'b1, 8'h80, 1'b1);
    test_branch(8'he6, 1'b1, 1'b0, 8'hff, 1'b0);
    test_bitclr(3'h7, 1'b0, 8'h85, 1'b0, 8'hc7, 12'hf85);
    test_bitclr(3'h0, 1'b0, 8'h12, 1'b0, 8'hff, 12'h012);
    test_bitclr(3'h3, 1'b1, 8'h12, 1'b1, 8'hff, 12'h312);
    test_bitclr(3'h5, 1'b0, 8'h5f, 1'b1, 8'h3c, 12'h15f);
    test_bitclr(3'h1, 1'b0, 8'h60, 1'b1, 8'h02, 12'h060);
    wrap_up();
  end
endmodule : flag_branch_bit_clear_exec_tb

// ==== verilog/fbx_exec.sv ====
// executes the carry and negative branches and the register bit clear
`timescale 1ns/1ps
// Notes on behaviour
// - opcode high byte e2 branches only when carry is one, else falls through.
// - the negative branch is taken only when the negative flag is one.
// - negative branch recognised by high byte e6, low byte is the offset.
// - offset is signed eight bits, -128..127, doubled before the add.
// - taken target is instruction address plus two plus twice the offset.
// - not taken is one cycle; taken adds one idle no-operation cycle.
// - high nibble 9 with bit index and bank bit clears that register bit.
// - bank bit zero picks the fixed access bank, ignoring bank select.
// - bank bit one picks the bank held in the bank select register.
// - extended set, bank bit zero, address up to 5f uses indexed mode.
module fbx_exec
  import fbx_pkg::*;
#(
  parameter int PCW = PC_WIDTH
) (
  input  wire logic [15:0]  instr,      // instruction word under execution
  input  wire logic         instrValid, // word present, sampled in phase four
  input  wire logic         carry,      // carry status flag
  input  wire logic         negative,   // negative status flag
  input  wire logic         extEnable,  // extended instruction set enabled
  input  wire logic [3:0]   bankSelect, // bank select register contents
  input  wire logic [11:0]  fsrBase,    // index base for literal-offset mode
  input  wire logic [7:0]   memRdata,   // data memory read value
  input  wire logic         clk,        // core clock, 125 MHz
  input  wire logic         nrst,       // sync reset, active low
  output fbx_mem_t          mem,        // data memory request
  output logic [PCW-1:0]    pc,         // program counter
  output logic              pcLoad,     // pulse when branch writes counter
  output logic              idleCycle,  // high through the idle cycle
  output logic              cycDone,    // pulse at each cycle end
  output logic [1:0]        qPhase      // phase, registered one clock behind
);
  logic [1:0] phase;
  logic       cycEnd;
  logic [15:0] ir;
  logic        irValid;
  logic        idle;
  logic [7:0]  rdHold;

  // free-running: one instruction word every four clocks
  fbx_phase_gen u_phase (
    .clk    (clk),
    .nrst   (nrst),
    .run    (1'b1),
    .phase  (phase),
    .cycEnd (cycEnd)
  );

  // decode
  wire isBrCarry = irValid && !idle
                   && ir[15:OPC_HI_POS] == OPC_BR_CARRY;
  wire isBrNeg   = irValid && !idle
                   && ir[15:OPC_HI_POS] == OPC_BR_NEG;
  wire isBitClr  = irValid && !idle && ir[15:12] == OPC_BITCLR;
  wire takeBr    = (isBrCarry && carry)
                   || (isBrNeg && negative);

  // signed word offset; pc already points past this instruction
  wire logic [PCW-1:0] ofsExt = PCW'(signed'(ir[7:0]));
  wire logic [PCW-1:0] target = pc + (ofsExt << 1);

  // operand address selection
  wire        accBit   = ir[ACC_BIT_POS];
  wire [2:0]  bitIdx   = ir[BIT_IDX_POS +: 3];
  wire [7:0]  fAddr    = ir[7:0];
  wire fbx_mode_t mode = accBit ? MODE_BANKED
                         : (extEnable && fAddr <= LIT_OFS_MAX)
                           ? MODE_INDEXED : MODE_ACCESS;
  wire [11:0] accAddr  = fAddr[7] ? {4'hf, fAddr} : {4'h0, fAddr};
  wire [11:0] opAddr   = (mode == MODE_BANKED) ? {bankSelect, fAddr}
                       : (mode == MODE_INDEXED)
                         ? fsrBase + {4'h0, fAddr} : accAddr;
  wire [7:0]  clrMask  = ~(8'h01 << bitIdx);
  wire [7:0]  wrData   = rdHold & clrMask;

  // mem is registered, so re shows in Q2 and we in Q4
  fbx_mem_t next_mem;
  always_comb begin
    next_mem      = '0;
    next_mem.addr = opAddr;
    next_mem.data = wrData;
    next_mem.re   = isBitClr && phase == PH_Q1;      // read in Q2
    next_mem.we   = isBitClr && phase == PH_Q3;      // write in Q4
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ir      <= 16'h0000;
      irValid <= 1'b0;
    end else if (phase == PH_Q4) begin
      ir      <= instr;
      irValid <= instrValid;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdHold <= 8'h00;
    end else if (phase == PH_Q2 && isBitClr) begin
      rdHold <= memRdata;
    end
  end

  // pc written at end of Q3 so it shows during Q4 of the branch
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pc     <= PCW'(PC_RESET);
      pcLoad <= 1'b0;
    end else begin
      pcLoad <= 1'b0;
      if (phase == PH_Q3 && takeBr) begin
        pc     <= target;
        pcLoad <= 1'b1;
      end else if (phase == PH_Q3 && !idle) begin
        pc <= pc + PCW'(2);   // sequential fall-through
      end
    end
  end

  // taken branch inserts one no-operation cycle; the fetched word is dropped
  always_ff @(posedge clk) begin
    if (!nrst) begin
      idle <= 1'b0;
    end else if (cycEnd) begin
      idle <= takeBr;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      mem       <= '0;
      idleCycle <= 1'b0;
      cycDone   <= 1'b0;
      qPhase    <= PH_Q1;
    end else begin
      mem       <= next_mem;
      idleCycle <= cycEnd ? takeBr : idle;
      cycDone   <= cycEnd;
      qPhase    <= phase;
    end
  end

  // checks
  AST_CARRY_TAKEN: assert property (@(posedge clk) disable iff (!nrst)
    phase == PH_Q3 && isBrCarry && carry |=> pcLoad && pc == $past(target))
    else $error("carry branch not taken");
  AST_CARRY_FALL: assert property (@(posedge clk) disable iff (!nrst)
    phase == PH_Q3 && isBrCarry && !carry |=> !pcLoad
      && pc == $past(pc) + PCW'(2))
    else $error("carry branch fell through wrongly");
  AST_NEG_TAKEN: assert property (@(posedge clk) disable iff (!nrst)
    phase == PH_Q3 && isBrNeg && negative |=> pcLoad)
    else $error("negative branch not taken");
  AST_NEG_FALL: assert property (@(posedge clk) disable iff (!nrst)
    phase == PH_Q3 && isBrNeg && !negative |=> !pcLoad
      && pc == $past(pc) + PCW'(2))
    else $error("negative branch fell through wrongly");
  AST_OFS_SIGN: assert property (@(posedge clk) disable iff (!nrst)
    phase == PH_Q3 && takeBr |=> pc - $past(pc)
      == {{(PCW-9){$past(ir[7])}}, $past(ir[7:0]), 1'b0})
    else $error("offset not sign extended and doubled");
  AST_TARGET: assert property (@(posedge clk) disable iff (!nrst)
    pcLoad |-> pc[0] == $past(pc[0], 1))
    else $error("target not word aligned");
  // the no-op cycle freezes the counter and is flagged for four clocks
  AST_IDLE_CYC: assert property (@(posedge clk) disable iff (!nrst)
    cycEnd && takeBr |=> idle [*4] ##1 !idle)
    else $error("idle cycle not exactly one cycle");
  AST_IDLE_OUT: assert property (@(posedge clk) disable iff (!nrst)
    cycEnd && takeBr |=> idleCycle)
    else $error("idle cycle not flagged");
  AST_IDLE_PC: assert property (@(posedge clk) disable iff (!nrst)
    idle && phase == PH_Q3 |=> pc == $past(pc))
    else $error("counter moved in idle cycle");
  AST_BR_NO_WR: assert property (@(posedge clk) disable iff (!nrst)
    phase == PH_Q3 && (isBrCarry || isBrNeg) |=> !mem.we)
    else $error("branch wrote data memory");
  AST_LOAD_PULSE: assert property (@(posedge clk) disable iff (!nrst)
    pcLoad |=> !pcLoad)
    else $error("counter load longer than one clock");
  AST_CYC_PERIOD: assert property (@(posedge clk) disable iff (!nrst)
    cycDone |=> !cycDone [*3] ##1 cycDone)
    else $error("instruction cycle not four clocks");
  AST_CLR_BIT: assert property (@(posedge clk) disable iff (!nrst)
    next_mem.we |-> next_mem.data[bitIdx] == 1'b0
      && (next_mem.data | (8'h01 << bitIdx))
         == ($past(memRdata) | (8'h01 << bitIdx)))
    else $error("bit clear corrupted data");
  AST_ACCESS: assert property (@(posedge clk) disable iff (!nrst)
    isBitClr && !accBit && !extEnable |-> opAddr == {{4{fAddr[7]}}, fAddr})
    else $error("access bank not used");
  AST_BANKED: assert property (@(posedge clk) disable iff (!nrst)
    isBitClr && accBit |-> opAddr[11:8] == bankSelect)
    else $error("bank select ignored");
  AST_INDEXED: assert property (@(posedge clk) disable iff (!nrst)
    isBitClr && !accBit && extEnable && fAddr <= LIT_OFS_MAX
      |-> mode == MODE_INDEXED)
    else $error("indexed mode not used");
  AST_RMW: assert property (@(posedge clk) disable iff (!nrst)
    next_mem.re |-> ##2 next_mem.we)
    else $error("write not two phases after read");
  AST_ONE_READ: assert property (@(posedge clk) disable iff (!nrst)
    mem.re |=> !mem.re)
    else $error("read longer than one phase");
  AST_CLR_PC: assert property (@(posedge clk) disable iff (!nrst)
    isBitClr && phase == PH_Q3 |=> !pcLoad
      && pc == $past(pc) + PCW'(2))
    else $error("bit clear changed program flow");

  COV_CARRY: cover property (@(posedge clk) disable iff (!nrst)
    pcLoad && $past(isBrCarry));
  COV_NEG_FALL: cover property (@(posedge clk) disable iff (!nrst)
    phase == PH_Q3 && isBrNeg && !negative);
  COV_CLR_IDX: cover property (@(posedge clk) disable iff (!nrst)
    next_mem.we && mode == MODE_INDEXED);
  COV_CLR_BANK: cover property (@(posedge clk) disable iff (!nrst)
    next_mem.we && mode == MODE_BANKED);
  COV_IDLE: cover property (@(posedge clk) disable iff (!nrst)
    idleCycle && cycDone);
endmodule : fbx_exec

// ==== verilog/fbx_phase_gen.sv ====
// four-phase divider producing a phase index and a one-cycle end pulse
`timescale 1ns/1ps
module fbx_phase_gen
  import fbx_pkg::*;
(
  input  wire logic       clk,     // core clock
  input  wire logic       nrst,    // sync reset, active low
  input  wire logic       run,     // advance phases
  output logic      [1:0] phase,   // current phase index
  output logic            cycEnd   // pulse in the last phase
);
  always_ff @(posedge clk) begin
    if (!nrst) begin
      phase <= PH_Q1;
    end else if (run) begin
      phase <= phase + 2'h1;
    end
  end

  assign cycEnd = run && (phase == PH_Q4);
endmodule : fbx_phase_gen

// ==== verilog/fbx_pkg.sv ====
// package: constants and carrier types for the branch and bit-clear executor
package fbx_pkg;
  localparam logic [7:0]  OPC_BR_CARRY = 8'he2;  // branch if carry set
  localparam logic [7:0]  OPC_BR_NEG   = 8'he6;  // branch if negative set
  localparam logic [3:0]  OPC_BITCLR   = 4'h9;   // clear register bit
  localparam int          OPC_HI_POS   = 8;
  localparam int          BIT_IDX_POS  = 9;
  localparam int          ACC_BIT_POS  = 8;
  localparam logic [7:0]  LIT_OFS_MAX  = 8'h5f;  // indexed mode limit
  localparam logic [1:0]  PH_Q1        = 2'h0;
  localparam logic [1:0]  PH_Q2        = 2'h1;
  localparam logic [1:0]  PH_Q3        = 2'h2;
  localparam logic [1:0]  PH_Q4        = 2'h3;
  localparam logic [20:0] PC_RESET     = 21'h000000;
  localparam int          PC_WIDTH     = 21;

  typedef enum logic [1:0] {
    MODE_BANKED,
    MODE_ACCESS,
    MODE_INDEXED
  } fbx_mode_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  data;
    logic        we;
    logic        re;
  } fbx_mem_t;
endpackage : fbx_pkg
